// File: design/clkm_pkg.sv
package clkm_pkg;

  // Bus geometry, word-indexed registers
  localparam int CLKM_ADR_W = 12;
  localparam int CLKM_DAT_W = 32;
  localparam int CLKM_IDX_W = 10;

  // Register indices; byte address is four times the index
  localparam logic [9:0] CLKM_IDX_CTRL = 10'h097;
  localparam logic [9:0] CLKM_IDX_XOSC = 10'h098;
  localparam logic [9:0] CLKM_IDX_IRQ_STS = 10'h099;
  localparam logic [9:0] CLKM_IDX_IRQ_EN = 10'h09A;
  localparam logic [9:0] CLKM_IDX_IRQ_CLR = 10'h09B;

  // Multiplier control fields
  localparam int CLKM_BIT_EN = 7;
  localparam int CLKM_BIT_INIT = 6;
  localparam int CLKM_BIT_RDY = 5;
  localparam int CLKM_SCALE_MSB = 4;
  localparam int CLKM_SCALE_LSB = 2;
  localparam int CLKM_SEL_MSB = 1;
  localparam int CLKM_SEL_LSB = 0;
  localparam int CLKM_SEL_X4_BIT = 1;

  // External oscillator control fields
  localparam int CLKM_MODE_MSB = 6;
  localparam int CLKM_MODE_LSB = 4;
  localparam int CLKM_FREQ_MSB = 2;
  localparam int CLKM_FREQ_LSB = 0;

  // Values after reset
  localparam logic [7:0] CLKM_CTRL_RST = 8'h00;
  localparam logic [7:0] CLKM_XOSC_RST = 8'h00;
  localparam logic [1:0] CLKM_IRQ_RST = 2'h0;
  localparam logic [31:0] CLKM_RD_ZERO = 32'h00000000;

  // Interrupt status layout
  localparam int CLKM_IRQ_W = 2;
  localparam int CLKM_IRQ_LOCK = 0;
  localparam int CLKM_IRQ_UNLOCK = 1;

  // External oscillator modes
  localparam logic [2:0] CLKM_XOSC_CMOS = 3'h2;
  localparam logic [2:0] CLKM_XOSC_XTAL = 3'h6;
  localparam logic [2:0] CLKM_XOSC_XTAL_DIV2 = 3'h7;

  // Output scaling
  localparam logic [2:0] CLKM_SCALE_MAX = 3'h5;
  localparam logic [2:0] CLKM_DEN_UNITY = 3'h2;
  localparam logic [2:0] CLKM_DEN_OFFSET = 3'h2;

  // Lock sequencer states
  typedef enum logic [3:0] {
    CLKM_LK_OFF = 4'h1,
    CLKM_LK_IDLE = 4'h2,
    CLKM_LK_ACQ = 4'h4,
    CLKM_LK_READY = 4'h8
  } clkm_lock_e;

  // Scale code to denominator of 2/den; reserved codes give unity
  function automatic logic [2:0] clkm_scale_den(input logic [2:0] code);
    if (code > CLKM_SCALE_MAX)
      return CLKM_DEN_UNITY;
    return code + CLKM_DEN_OFFSET;
  endfunction

endpackage

// File: design/clkm_lock_ctrl.sv
`timescale 1ns/1ns
module clkm_lock_ctrl
  import clkm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_sync_n,
  input wire logic clk_en,
  input wire logic mult_on,
  input wire logic init_req,
  input wire logic pll_lock,
  output logic ready,
  output logic init_pulse,
  output logic lock_gained,
  output logic lock_lost
);

  clkm_lock_e state_q;
  clkm_lock_e state_d;
  logic init_pulse_q;

  // Next state; disabling always wins and drops ready
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      CLKM_LK_OFF: if (mult_on) state_d = CLKM_LK_IDLE;
      CLKM_LK_IDLE: if (init_req) state_d = CLKM_LK_ACQ;
      CLKM_LK_ACQ: if (pll_lock && !init_req) state_d = CLKM_LK_READY;
      CLKM_LK_READY: if (init_req || !pll_lock) state_d = CLKM_LK_ACQ;
      default: state_d = CLKM_LK_OFF;
    endcase
    if (!mult_on)
      state_d = CLKM_LK_OFF;
  end

  // State and init strobe, frozen while clock enable is low
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_q <= CLKM_LK_OFF;
      init_pulse_q <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      init_pulse_q <= init_req;
    end
  end

  // Ready only after lock seen in acquisition
  assign ready = (state_q == CLKM_LK_READY);
  assign init_pulse = init_pulse_q;
  assign lock_gained = clk_en & (state_q == CLKM_LK_ACQ)
    & (state_d == CLKM_LK_READY);
  assign lock_lost = clk_en & (state_q == CLKM_LK_READY) & mult_on
    & !pll_lock & !init_req;

  AST_RDY_NEEDS_LOCK:
    assert property (@(posedge clock) disable iff (!rst_sync_n)
      $rose(ready) |-> $past(pll_lock))
    else $error("ready rose without lock");

  AST_OFF_CLEARS_RDY:
    assert property (@(posedge clock) disable iff (!rst_sync_n)
      (clk_en && !mult_on) |=> !ready)
    else $error("ready survived disable");

endmodule

// File: design/clkm_pin_assign.sv
`timescale 1ns/1ns
module clkm_pin_assign
  import clkm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_sync_n,
  input wire logic clk_en,
  input wire logic [2:0] osc_mode,
  output logic port0_pin2_osc,
  output logic port0_pin3_osc
);

  logic pin2_d;
  logic pin3_d;
  logic pin2_q;
  logic pin3_q;

  // Crystal takes both pins; CMOS, RC and C take only the second
  assign pin2_d = (osc_mode == CLKM_XOSC_XTAL)
    | (osc_mode == CLKM_XOSC_XTAL_DIV2);
  assign pin3_d = (osc_mode >= CLKM_XOSC_CMOS);

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pin2_q <= 1'b0;
      pin3_q <= 1'b0;
    end
    else if (clk_en)
    begin
      pin2_q <= pin2_d;
      pin3_q <= pin3_d;
    end
  end

  assign port0_pin2_osc = pin2_q;
  assign port0_pin3_osc = pin3_q;

  AST_PIN2_XTAL:
    assert property (@(posedge clock) disable iff (!rst_sync_n)
      clk_en |=> port0_pin2_osc == ($past(osc_mode) >= CLKM_XOSC_XTAL))
    else $error("first crystal pin ownership wrong");

  AST_PIN3_EXT:
    assert property (@(posedge clock) disable iff (!rst_sync_n)
      clk_en |=> port0_pin3_osc == ($past(osc_mode) >= CLKM_XOSC_CMOS))
    else $error("second crystal pin ownership wrong");

endmodule

// File: design/clkm_top.sv
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ns
module clkm_top
  import clkm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [clkm_pkg::CLKM_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [clkm_pkg::CLKM_DAT_W-1:0] wb_dat_i,
  output logic [clkm_pkg::CLKM_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pll_lock,
  output logic mult_enable,
  output logic mult_init,
  output logic [1:0] mult_input_select,
  output logic mult_base_x4,
  output logic [2:0] mult_scale_den,
  output logic mult_duty_uneven,
  output logic [2:0] external_oscillator_mode,
  output logic [2:0] external_frequency_control,
  output logic port0_pin2_osc,
  output logic port0_pin3_osc,
  output logic irq
);
  import clkm_pkg::*;

  logic rst_meta_n_q;
  logic rst_sync_n_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic enable_q;
  logic init_q;
  logic [2:0] scale_q;
  logic [1:0] sel_q;
  logic [2:0] mode_q;
  logic [2:0] freq_q;
  logic [1:0] app_sel_q;
  logic [2:0] app_den_q;
  logic app_duty_q;
  logic [CLKM_IRQ_W-1:0] sts_q;
  logic [CLKM_IRQ_W-1:0] sts_d;
  logic [CLKM_IRQ_W-1:0] irq_en_q;

  // Reset released through two stages; only the second is used
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n_q <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_n_q <= 1'b1;
      rst_sync_n_q <= rst_meta_n_q;
    end
  end

  // Bus decode; a new request is taken only between acks
  logic [CLKM_IDX_W-1:0] bus_idx;
  logic bus_take;
  logic wr_lane0;
  logic hit_ctrl;
  logic hit_xosc;
  logic hit_sts;
  logic hit_en;
  logic ctrl_wr;
  logic xosc_wr;
  logic en_wr;
  logic init_req;
  logic [2:0] new_scale;
  logic [1:0] new_sel;
  logic [2:0] new_den;
  logic [CLKM_IRQ_W-1:0] clr_mask;
  logic [CLKM_IRQ_W-1:0] events;
  logic ready;
  logic lock_gained;
  logic lock_lost;
  logic [7:0] ctrl_byte;
  logic [7:0] xosc_byte;
  logic [31:0] rd_mux;

  assign bus_idx = wb_adr_i[CLKM_ADR_W-1:2];
  assign bus_take = clk_en & wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_lane0 = bus_take & wb_we_i & wb_sel_i[0];
  assign hit_ctrl = (bus_idx == CLKM_IDX_CTRL);
  assign hit_xosc = (bus_idx == CLKM_IDX_XOSC);
  assign hit_sts = (bus_idx == CLKM_IDX_IRQ_STS);
  assign hit_en = (bus_idx == CLKM_IDX_IRQ_EN);
  assign ctrl_wr = wr_lane0 & hit_ctrl;
  assign xosc_wr = wr_lane0 & hit_xosc;
  assign en_wr = wr_lane0 & hit_en;

  // Init only counts when the multiplier was already on and stays on
  assign init_req = ctrl_wr & enable_q & wb_dat_i[CLKM_BIT_EN]
    & wb_dat_i[CLKM_BIT_INIT];

  // Settings captured at init; times-2 sources bypass scaling
  assign new_sel = wb_dat_i[CLKM_SEL_MSB:CLKM_SEL_LSB];
  assign new_scale = wb_dat_i[CLKM_SCALE_MSB:CLKM_SCALE_LSB];
  assign new_den = new_sel[CLKM_SEL_X4_BIT]
    ? clkm_scale_den(new_scale) : CLKM_DEN_UNITY;

  // Control and oscillator registers, all zero after reset
  always_ff @(posedge clock or negedge rst_sync_n_q)
  begin
    if (!rst_sync_n_q)
    begin
      {enable_q, init_q, scale_q, sel_q} <= {CLKM_CTRL_RST[7:6],
        CLKM_CTRL_RST[4:0]};
      {mode_q, freq_q} <= {CLKM_XOSC_RST[6:4], CLKM_XOSC_RST[2:0]};
    end
    else if (ctrl_wr)
    begin
      enable_q <= wb_dat_i[CLKM_BIT_EN];
      init_q <= wb_dat_i[CLKM_BIT_INIT];
      scale_q <= new_scale;
      sel_q <= new_sel;
    end
    else if (xosc_wr)
    begin
      mode_q <= wb_dat_i[CLKM_MODE_MSB:CLKM_MODE_LSB];
      freq_q <= wb_dat_i[CLKM_FREQ_MSB:CLKM_FREQ_LSB];
    end
  end

  // Applied settings move only on an accepted init
  always_ff @(posedge clock or negedge rst_sync_n_q)
  begin
    if (!rst_sync_n_q)
    begin
      app_sel_q <= CLKM_CTRL_RST[1:0];
      app_den_q <= CLKM_DEN_UNITY;
      app_duty_q <= 1'b0;
    end
    else if (init_req)
    begin
      app_sel_q <= new_sel;
      app_den_q <= new_den;
      app_duty_q <= new_den[0];
    end
  end

  // Interrupts: set beats clear in the same cycle
  assign events = {lock_lost, lock_gained};
  assign clr_mask = (wr_lane0 && bus_idx == CLKM_IDX_IRQ_CLR)
    ? wb_dat_i[CLKM_IRQ_W-1:0] : CLKM_IRQ_RST;
  assign sts_d = (sts_q & ~clr_mask) | events;

  always_ff @(posedge clock or negedge rst_sync_n_q)
  begin
    if (!rst_sync_n_q)
    begin
      sts_q <= CLKM_IRQ_RST;
      irq_en_q <= CLKM_IRQ_RST;
    end
    else if (clk_en)
    begin
      sts_q <= sts_d;
      if (en_wr)
        irq_en_q <= wb_dat_i[CLKM_IRQ_W-1:0];
    end
  end

  // Read mux; ready is live state, unmapped words read zero
  assign ctrl_byte = {enable_q, init_q, ready, scale_q, sel_q};
  assign xosc_byte = {1'b0, mode_q, 1'b0, freq_q};
  assign rd_mux = hit_ctrl ? {24'h000000, ctrl_byte}
    : hit_xosc ? {24'h000000, xosc_byte}
    : hit_sts ? {30'h00000000, sts_q}
    : hit_en ? {30'h00000000, irq_en_q}
    : CLKM_RD_ZERO;

  // Registered ack one cycle after the request is taken
  always_ff @(posedge clock or negedge rst_sync_n_q)
  begin
    if (!rst_sync_n_q)
    begin
      ack_q <= 1'b0;
      rdat_q <= CLKM_RD_ZERO;
    end
    else if (clk_en)
    begin
      ack_q <= bus_take;
      if (bus_take)
        rdat_q <= wb_we_i ? CLKM_RD_ZERO : rd_mux;
    end
  end

  clkm_lock_ctrl u_lock (
    .clock(clock),
    .rst_sync_n(rst_sync_n_q),
    .clk_en(clk_en),
    .mult_on(enable_q),
    .init_req(init_req),
    .pll_lock(pll_lock),
    .ready(ready),
    .init_pulse(mult_init),
    .lock_gained(lock_gained),
    .lock_lost(lock_lost)
  );

  clkm_pin_assign u_pins (
    .clock(clock),
    .rst_sync_n(rst_sync_n_q),
    .clk_en(clk_en),
    .osc_mode(mode_q),
    .port0_pin2_osc(port0_pin2_osc),
    .port0_pin3_osc(port0_pin3_osc)
  );

  // Outputs
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign mult_enable = enable_q;
  assign mult_input_select = app_sel_q;
  assign mult_base_x4 = app_sel_q[CLKM_SEL_X4_BIT];
  assign mult_scale_den = app_den_q;
  assign mult_duty_uneven = app_duty_q;
  assign external_oscillator_mode = mode_q;
  assign external_frequency_control = freq_q;
  assign irq = |(sts_q & irq_en_q);

  default clocking dclk @(posedge clock);
  endclocking
  default disable iff (!rst_sync_n_q);

  AST_INIT_FOLLOWS:
    assert property (init_req |=> mult_init)
    else $error("init write gave no init strobe");

  AST_INIT_NEEDS_EN:
    assert property ($rose(mult_init) |-> mult_enable && $past(enable_q))
    else $error("init strobe while multiplier off");

  // A frozen cycle may hold ready past a lock drop or a disable
  AST_RDY_NEEDS_EN:
    assert property (ready |-> !$past(clk_en)
      || ($past(pll_lock) && $past(mult_enable)))
    else $error("ready without enable or lock");

  AST_SEL_APPLIED:
    assert property (init_req |=> mult_input_select == $past(new_sel))
    else $error("source select not applied at init");

  AST_X2_NO_SCALE:
    assert property (!mult_base_x4 |-> mult_scale_den == CLKM_DEN_UNITY)
    else $error("times-2 source was scaled");

  AST_DEN_RANGE:
    assert property (mult_scale_den >= 3'h2 && mult_scale_den <= 3'h7)
    else $error("scale denominator out of range");

  AST_DUTY_ODD:
    assert property (mult_duty_uneven == mult_scale_den[0])
    else $error("duty flag disagrees with scaling");

  AST_HOLD_CFG:
    assert property (!init_req |=> $stable(mult_input_select)
      && $stable(mult_scale_den))
    else $error("applied settings moved without init");

  AST_RST_ZERO:
    assert property ($rose(rst_sync_n_q) |-> ctrl_byte == CLKM_CTRL_RST)
    else $error("control register not zero after reset");

  AST_ACK_ONE: // bus answer is one cycle
    assert property (bus_take |=> wb_ack_o ##1 (!wb_ack_o || !$past(clk_en)))
    else $error("ack timing wrong");

  AST_STS_SET_WINS:
    assert property (clk_en && lock_gained |=> sts_q[CLKM_IRQ_LOCK])
    else $error("lock event lost");

  AST_STS_CLEARS:
    assert property (clr_mask[CLKM_IRQ_UNLOCK] && !lock_lost
      |=> !sts_q[CLKM_IRQ_UNLOCK])
    else $error("status bit survived its clear");

  AST_RDY_FLAGS_LOCK:
    assert property ($rose(ready) |-> sts_q[CLKM_IRQ_LOCK])
    else $error("ready rose without lock status");

  CVR_LOCK: cover property (init_req ##[1:200] $rose(ready));
  CVR_RELOCK: cover property (ready ##1 init_req);
  CVR_UNLOCK: cover property (ready && lock_lost);
  CVR_XTAL: cover property (port0_pin2_osc && port0_pin3_osc);
  CVR_FREEZE: cover property (!clk_en && wb_cyc_i && wb_stb_i);

endmodule

// File: tb/clkm_pll_model.sv
`timescale 1ns/1ns
// Analog loop stand-in: locks a fixed time after each init pulse
module clkm_pll_model #(
  parameter int LOCK_CYC = 6
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic mult_enable,
  input wire logic mult_init,
  output logic pll_lock
);
  int cnt_q;

  // Lock only counts from init, the source is stable by then
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 0;
      pll_lock <= 1'b0;
    end
    else if (!mult_enable)
    begin
      cnt_q <= 0;
      pll_lock <= 1'b0;
    end
    else if (mult_init)
    begin
      cnt_q <= LOCK_CYC;
      pll_lock <= 1'b0;
    end
    else if (cnt_q == 1)
    begin
      cnt_q <= 0;
      pll_lock <= 1'b1;
    end
    else if (cnt_q > 1)
    begin
      cnt_q <= cnt_q - 1;
    end
  end
endmodule

// File: tb/test_clock_multiplier_control.sv
`timescale 1ns/1ns
module test_clock_multiplier_control;
  import clkm_pkg::*;
  logic clock;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic ce = 1'b1;
  logic we = 1'b0;
  logic [CLKM_ADR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [CLKM_DAT_W-1:0] dat_w = '0;
  logic [CLKM_DAT_W-1:0] dat_o;
  logic [CLKM_DAT_W-1:0] dat_r;
  logic ack, pll_lock, m_en, m_init, x4, uneven, pin2, pin3, irq;
  logic init_seen;
  logic [1:0] msel;
  logic [2:0] den, xmode, xfreq;
  int error_cnt = 0;
  int checks_done = 0;

  clkm_top i_dut (.clock(clock), .rst_n(rst_n), .clk_en(ce),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .pll_lock(pll_lock), .mult_enable(m_en), .mult_init(m_init),
    .mult_input_select(msel), .mult_base_x4(x4), .mult_scale_den(den),
    .mult_duty_uneven(uneven), .external_oscillator_mode(xmode),
    .external_frequency_control(xfreq), .port0_pin2_osc(pin2),
    .port0_pin3_osc(pin3), .irq(irq));

  clkm_pll_model i_pll (.clock(clock), .rst_n(rst_n), .mult_enable(m_en),
    .mult_init(m_init), .pll_lock(pll_lock));

  // 20 MHz system clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // One classic cycle; entered just after a rising edge
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    dat_w <= {24'h0, d};
    @(posedge clock);
    while (ack !== 1'b1 && n < 50)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 50)
      error_cnt++;
    dat_r = dat_o;
    init_seen = m_init;
    cyc <= 1'b0;
    @(posedge clock);
  endtask

  task automatic t_reset();
    wb(0, CLKM_IDX_CTRL, 8'h00);
    chk(32'h0, dat_r);
    wb(0, CLKM_IDX_XOSC, 8'h00);
    chk(32'h0, dat_r);
    wb(0, CLKM_IDX_IRQ_STS, 8'h00);
    chk(32'h0, dat_r);
    chk(32'h2, den);
    wb(1, 10'h3FF, 8'hFF);
    wb(0, 10'h3FF, 8'h00);
    chk(32'h0, dat_r);
  endtask

  // Init while disabled, written or current, is ignored
  task automatic t_refused();
    wb(1, CLKM_IDX_CTRL, 8'h43);
    chk(32'h0, init_seen);
    wb(1, CLKM_IDX_CTRL, 8'hC3);
    chk(32'h0, init_seen);
    chk(32'h0, msel);
    wb(1, CLKM_IDX_CTRL, 8'h00);
  endtask

  task automatic t_bringup();
    int n;
    // Outer source times 4 scaled to 2/3 keeps the system clock in range
    wb(1, CLKM_IDX_CTRL, 8'h87);
    chk(32'h1, m_en);
    chk(32'h0, msel);
    repeat (101) @(posedge clock);
    wb(1, CLKM_IDX_IRQ_EN, 8'h01);
    wb(1, CLKM_IDX_CTRL, 8'hC7);
    chk(32'h1, init_seen);
    chk(32'h7, {x4, msel});
    chk(32'h3, den);
    chk(32'h1, uneven);
    wb(0, CLKM_IDX_CTRL, 8'h00);
    chk(32'hC7, dat_r);
    n = 0;
    while (dat_r[CLKM_BIT_RDY] !== 1'b1 && n < 20)
    begin
      wb(0, CLKM_IDX_CTRL, 8'h00);
      n++;
    end
    chk(32'hE7, dat_r);
    chk(32'h1, irq);
    wb(0, CLKM_IDX_IRQ_STS, 8'h00);
    chk(32'h1, dat_r);
    wb(1, CLKM_IDX_IRQ_EN, 8'h00);
    chk(32'h0, irq);
    wb(1, CLKM_IDX_IRQ_EN, 8'h01);
    chk(32'h1, irq);
    wb(1, CLKM_IDX_IRQ_CLR, 8'h01);
    chk(32'h0, irq);
  endtask

  // Every select and scale code through an init
  task automatic t_scale();
    logic [2:0] e;
    for (int m = 0; m < 4; m++)
    begin
      for (int s = 0; s < 8; s++)
      begin
        e = (m < 2 || s > 5) ? 3'h2 : 3'(s + 2);
        wb(1, CLKM_IDX_CTRL, 8'hC0 | 8'(s << 2) | 8'(m));
        chk(32'(m + (m / 2) * 4), {x4, msel});
        chk(32'(e), den);
        chk(32'(e[0]), uneven);
      end
    end
  endtask

  // Clock enable low holds off the take, so the answer comes late
  task automatic t_freeze();
    time t0;
    t0 = $time;
    ce <= 1'b0;
    fork
      begin
        repeat (4) @(posedge clock);
        chk(32'h0, ack);
        ce <= 1'b1;
      end
    join_none
    wb(1, CLKM_IDX_IRQ_EN, 8'h03);
    chk(32'h15E, 32'($time - t0));
    wb(0, CLKM_IDX_IRQ_EN, 8'h00);
    chk(32'h3, dat_r);
  endtask

  task automatic t_disable();
    repeat (10) @(posedge clock);
    wb(1, CLKM_IDX_IRQ_EN, 8'h02);
    wb(1, CLKM_IDX_CTRL, 8'h00);
    chk(32'h0, m_en);
    wb(0, CLKM_IDX_CTRL, 8'h00);
    chk(32'h0, dat_r);
    chk(32'h1, irq);
    wb(0, CLKM_IDX_IRQ_STS, 8'h00);
    chk(32'h3, dat_r);
    wb(1, CLKM_IDX_IRQ_CLR, 8'h03);
    chk(32'h0, irq);
  endtask

  // Pin claims for each oscillator mode
  task automatic t_pins();
    for (int m = 0; m < 8; m++)
    begin
      wb(1, CLKM_IDX_XOSC, 8'(m << 4) | 8'h0D);
      repeat (2) @(posedge clock);
      chk(32'(m >= 6), pin2);
      chk(32'(m >= 2), pin3);
      chk(32'(m), xmode);
      chk(32'h5, xfreq);
    end
  endtask

  task automatic wrap_up();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_refused();
    t_bringup();
    t_scale();
    t_freeze();
    t_disable();
    t_pins();
    wrap_up();
  end

  // Hang guard, well beyond the few hundred cycles needed
  initial
  begin
    #(50 * 20000);
    error_cnt++;
    wrap_up();
  end
endmodule
